//--- logic/crf_regs.svh
// Purpose: Named offsets, field positions, reset values and bounds.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one word each.
// Notes: Included by its bare name from every file except the package.
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define CRF_OFS_D0 8'h00
`define CRF_OFS_D1 8'h04
`define CRF_OFS_D2 8'h08
`define CRF_OFS_D3 8'h0c
`define CRF_OFS_A0 8'h10
`define CRF_OFS_A1 8'h14
`define CRF_OFS_FB 8'h18
`define CRF_OFS_PC 8'h1c
`define CRF_OFS_VTB 8'h20
`define CRF_OFS_USP 8'h24
`define CRF_OFS_TSP 8'h28
`define CRF_OFS_SBR 8'h2c
`define CRF_OFS_FLAG 8'h30
`define CRF_OFS_ASP 8'h34
`define CRF_OFS_LPL 8'h38
`define CRF_OFS_LPH 8'h3c
`define CRF_OFS_LAP 8'h40
`define CRF_OFS_D0LB 8'h44
`define CRF_OFS_D0UB 8'h48
`define CRF_OFS_D1LB 8'h4c
`define CRF_OFS_D1UB 8'h50

// ****************************************************************
// Banked register slots.
// ****************************************************************
`define CRF_SLOT_D0 3'h0
`define CRF_SLOT_D1 3'h1
`define CRF_SLOT_D2 3'h2
`define CRF_SLOT_D3 3'h3
`define CRF_SLOT_A0 3'h4
`define CRF_SLOT_A1 3'h5
`define CRF_SLOT_FB 3'h6
`define CRF_SLOT_LAST 3'h6
`define CRF_SLOT_CNT 7

// ****************************************************************
// Flag word fields.
// ****************************************************************
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7
`define CRF_FLG_IPL_LO 12
`define CRF_FLG_IPL_HI 14
`define CRF_FLG_MASK 16'h70ff
`define CRF_FLG_RST 16'h0000
`define CRF_TRAP_LAST 6'h1f

// ****************************************************************
// Reset values and memory map bounds.
// ****************************************************************
`define CRF_R16_RST 16'h0000
`define CRF_R20_RST 20'h00000
`define CRF_SFR_LO 20'h00000
`define CRF_SFR_HI 20'h003ff
`define CRF_SPV_LO 20'hffe00
`define CRF_SPV_HI 20'hfffdb
`define CRF_FIXV_LO 20'hfffdc
`define CRF_FIXV_HI 20'hfffff

`endif

//--- logic/crf_pkg.sv
// Purpose: Shared types of the register file block.
// Assumes: Constants come from crf_regs.svh.
// Notes: Types only.
package crf_pkg;

	// Region of the address space that a fetch address falls in.
	typedef enum logic [1:0] {
		CRF_RGN_OTHER = 2'h0,
		CRF_RGN_SFR = 2'h1,
		CRF_RGN_SPAGE = 2'h2,
		CRF_RGN_FIXVEC = 2'h3
	} crf_region_t;

	// Bus slave states, Gray along idle to active.
	typedef enum logic [1:0] {
		CRF_BUS_IDLE = 2'h0,
		CRF_BUS_ACT = 2'h1
	} crf_bus_st_t;

	// Operand addressing modes.
	typedef enum logic [2:0] {
		CRF_AG_A0_IND = 3'h0,
		CRF_AG_A1_REL = 3'h1,
		CRF_AG_FB_REL = 3'h2,
		CRF_AG_SB_REL = 3'h3,
		CRF_AG_LONG = 3'h4
	} crf_agen_t;

endpackage

//--- logic/crf_flag_unit.sv
// Purpose: Holds the processor flag word and all of its update paths.
// Assumes: All strobes are single-cycle pulses on core_clk.
// Notes: Interrupt clears take priority over software and ALU writes.
`timescale 1ns/1ns
`include "crf_regs.svh"

module crf_flag_unit (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sw_we,
	input wire logic [15:0] sw_data,
	input wire logic alu_we,
	input wire logic alu_carry,
	input wire logic [15:0] alu_result,
	input wire logic alu_ovf,
	input wire logic int_ack,
	input wire logic step_ack,
	input wire logic trap_exec,
	input wire logic [5:0] trap_num,
	output logic [15:0] flag_reg
);
	import crf_pkg::*;

	logic [15:0] flag_next;

	// Next flag value: software, then ALU, then interrupt clears.
	always_comb begin
		flag_next = flag_reg;
		if (sw_we) begin
			flag_next = sw_data & `CRF_FLG_MASK;
		end
		if (alu_we) begin
			flag_next[`CRF_FLG_C] = alu_carry;
			flag_next[`CRF_FLG_Z] = (alu_result == `CRF_R16_RST);
			flag_next[`CRF_FLG_S] = alu_result[15];
			flag_next[`CRF_FLG_O] = alu_ovf;
		end
		if (step_ack) begin
			flag_next[`CRF_FLG_D] = 1'b0;
		end
		if (int_ack) begin
			flag_next[`CRF_FLG_I] = 1'b0;
			flag_next[`CRF_FLG_U] = 1'b0;
		end
		if (trap_exec && (trap_num <= `CRF_TRAP_LAST)) begin
			flag_next[`CRF_FLG_U] = 1'b0;
		end
	end

	// Flag storage.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flag_reg <= `CRF_FLG_RST;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule

//--- logic/crf_core_regs.sv
// Purpose: Architectural register state of the core with AHB-Lite access.
// Assumes: Core-side strobes are synchronous one-cycle pulses.
// Notes: Every bus transfer takes one wait state; hresp is always OKAY.
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "crf_regs.svh"

module crf_core_regs (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic alu_we,
	input wire logic alu_carry,
	input wire logic [15:0] alu_result,
	input wire logic alu_ovf,
	input wire logic instr_done,
	input wire logic int_ack,
	input wire logic step_ack,
	input wire logic trap_exec,
	input wire logic [5:0] trap_num,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic pc_load,
	input wire logic [19:0] pc_value,
	input wire crf_pkg::crf_agen_t agen_mode,
	input wire logic [15:0] agen_disp,
	input wire logic [19:0] fetch_addr,
	output logic [19:0] agen_addr,
	output logic [19:0] pc_out,
	output logic [15:0] stack_ptr,
	output logic bank_sel,
	output logic step_irq,
	output logic irq_take,
	output crf_pkg::crf_region_t fetch_region
);
	import crf_pkg::*;

	// ************************************************************
	// Storage.
	// ************************************************************
	logic [15:0] bank_mem [0:1][0:`CRF_SLOT_CNT-1];
	logic [19:0] pc_reg;
	logic [19:0] vtb_reg;
	logic [15:0] usp_reg;
	logic [15:0] tsp_reg;
	logic [15:0] sbr_reg;
	logic [15:0] flag_word;
	crf_bus_st_t bus_st_reg;
	logic [7:0] addr_q_reg;
	logic wr_q_reg;
	logic [31:0] rd_value;
	logic wr_hit;
	logic flag_we;
	logic bsel;

	// ************************************************************
	// Helper functions.
	// ************************************************************

	// Classifies an address into one of the decoded regions.
	function automatic crf_region_t region_of(input logic [19:0] a);
		if (a >= `CRF_FIXV_LO) begin
			region_of = CRF_RGN_FIXVEC;
		end else if (a >= `CRF_SPV_LO && a <= `CRF_SPV_HI) begin
			region_of = CRF_RGN_SPAGE;
		end else if (a <= `CRF_SFR_HI) begin
			region_of = CRF_RGN_SFR;
		end else begin
			region_of = CRF_RGN_OTHER;
		end
	endfunction

	// Adds a 16-bit base and displacement into a 20-bit address.
	function automatic logic [19:0] rel_addr(input logic [15:0] b,
		input logic [15:0] d);
		rel_addr = {4'h0, b} + {4'h0, d};
	endfunction

	// Picks the stack pointer that the select flag chooses.
	function automatic logic [15:0] pick_sp(input logic u,
		input logic [15:0] user_stack_pointer, input logic [15:0] tsp);
		pick_sp = u ? user_stack_pointer : tsp;
	endfunction

	assign bsel = flag_word[`CRF_FLG_B];
	assign wr_hit = (bus_st_reg == CRF_BUS_ACT) && wr_q_reg;
	assign flag_we = wr_hit && (addr_q_reg == `CRF_OFS_FLAG);

	// ************************************************************
	// Flag word.
	// ************************************************************
	crf_flag_unit u_flags (
		.core_clk(core_clk),
		.nrst(nrst),
		.sw_we(flag_we),
		.sw_data(hwdata[15:0]),
		.alu_we(alu_we),
		.alu_carry(alu_carry),
		.alu_result(alu_result),
		.alu_ovf(alu_ovf),
		.int_ack(int_ack),
		.step_ack(step_ack),
		.trap_exec(trap_exec),
		.trap_num(trap_num),
		.flag_reg(flag_word)
	);

	// ************************************************************
	// AHB-Lite slave control.
	// ************************************************************

	// Takes an address phase, then answers after one wait cycle.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bus_st_reg <= CRF_BUS_IDLE;
			addr_q_reg <= 8'h00;
			wr_q_reg <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			case (bus_st_reg)
				CRF_BUS_IDLE: begin
					if (hsel && htrans[1] && hready) begin
						bus_st_reg <= CRF_BUS_ACT;
						addr_q_reg <= haddr[7:0];
						wr_q_reg <= hwrite;
						hreadyout <= 1'b0;
					end
				end
				default: begin
					bus_st_reg <= CRF_BUS_IDLE;
					wr_q_reg <= 1'b0;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// The response is always OKAY.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// Read multiplexer over the active bank; unmapped reads give zero.
	always_comb begin
		rd_value = 32'h00000000;
		if (addr_q_reg == `CRF_OFS_D0) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_D0];
		end else if (addr_q_reg == `CRF_OFS_D1) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_D1];
		end else if (addr_q_reg == `CRF_OFS_D2) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_D2];
		end else if (addr_q_reg == `CRF_OFS_D3) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_D3];
		end else if (addr_q_reg == `CRF_OFS_A0) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_A0];
		end else if (addr_q_reg == `CRF_OFS_A1) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_A1];
		end else if (addr_q_reg == `CRF_OFS_FB) begin
			rd_value[15:0] = bank_mem[bsel][`CRF_SLOT_FB];
		end else if (addr_q_reg == `CRF_OFS_PC) begin
			rd_value[19:0] = pc_reg;
		end else if (addr_q_reg == `CRF_OFS_VTB) begin
			rd_value[19:0] = vtb_reg;
		end else if (addr_q_reg == `CRF_OFS_USP) begin
			rd_value[15:0] = usp_reg;
		end else if (addr_q_reg == `CRF_OFS_TSP) begin
			rd_value[15:0] = tsp_reg;
		end else if (addr_q_reg == `CRF_OFS_SBR) begin
			rd_value[15:0] = sbr_reg;
		end else if (addr_q_reg == `CRF_OFS_FLAG) begin
			rd_value[15:0] = flag_word;
		end else if (addr_q_reg == `CRF_OFS_ASP) begin
			rd_value[15:0] = pick_sp(flag_word[`CRF_FLG_U], usp_reg,
				tsp_reg);
		end else if (addr_q_reg == `CRF_OFS_LPL) begin
			rd_value = {bank_mem[bsel][`CRF_SLOT_D2],
				bank_mem[bsel][`CRF_SLOT_D0]};
		end else if (addr_q_reg == `CRF_OFS_LPH) begin
			rd_value = {bank_mem[bsel][`CRF_SLOT_D3],
				bank_mem[bsel][`CRF_SLOT_D1]};
		end else if (addr_q_reg == `CRF_OFS_LAP) begin
			rd_value = {bank_mem[bsel][`CRF_SLOT_A1],
				bank_mem[bsel][`CRF_SLOT_A0]};
		end else if (addr_q_reg == `CRF_OFS_D0LB) begin
			rd_value[7:0] = bank_mem[bsel][`CRF_SLOT_D0][7:0];
		end else if (addr_q_reg == `CRF_OFS_D0UB) begin
			rd_value[7:0] = bank_mem[bsel][`CRF_SLOT_D0][15:8];
		end else if (addr_q_reg == `CRF_OFS_D1LB) begin
			rd_value[7:0] = bank_mem[bsel][`CRF_SLOT_D1][7:0];
		end else if (addr_q_reg == `CRF_OFS_D1UB) begin
			rd_value[7:0] = bank_mem[bsel][`CRF_SLOT_D1][15:8];
		end
	end

	// Read data is loaded in the wait cycle so it sees prior writes.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (bus_st_reg == CRF_BUS_ACT && !wr_q_reg) begin
			hrdata <= rd_value;
		end
	end

	// ************************************************************
	// Banked registers.
	// ************************************************************

	// Writes land only in the bank the flag selects.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int b = 0; b < 2; b++) begin
				for (int s = 0; s < `CRF_SLOT_CNT; s++) begin
					bank_mem[b][s] <= `CRF_R16_RST;
				end
			end
		end else if (wr_hit) begin
			if (addr_q_reg == `CRF_OFS_D0) begin
				bank_mem[bsel][`CRF_SLOT_D0] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_D1) begin
				bank_mem[bsel][`CRF_SLOT_D1] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_D2) begin
				bank_mem[bsel][`CRF_SLOT_D2] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_D3) begin
				bank_mem[bsel][`CRF_SLOT_D3] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_A0) begin
				bank_mem[bsel][`CRF_SLOT_A0] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_A1) begin
				bank_mem[bsel][`CRF_SLOT_A1] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_FB) begin
				bank_mem[bsel][`CRF_SLOT_FB] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_LPL) begin
				bank_mem[bsel][`CRF_SLOT_D2] <= hwdata[31:16];
				bank_mem[bsel][`CRF_SLOT_D0] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_LPH) begin
				bank_mem[bsel][`CRF_SLOT_D3] <= hwdata[31:16];
				bank_mem[bsel][`CRF_SLOT_D1] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_LAP) begin
				bank_mem[bsel][`CRF_SLOT_A1] <= hwdata[31:16];
				bank_mem[bsel][`CRF_SLOT_A0] <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_D0LB) begin
				bank_mem[bsel][`CRF_SLOT_D0][7:0] <= hwdata[7:0];
			end else if (addr_q_reg == `CRF_OFS_D0UB) begin
				bank_mem[bsel][`CRF_SLOT_D0][15:8] <= hwdata[7:0];
			end else if (addr_q_reg == `CRF_OFS_D1LB) begin
				bank_mem[bsel][`CRF_SLOT_D1][7:0] <= hwdata[7:0];
			end else if (addr_q_reg == `CRF_OFS_D1UB) begin
				bank_mem[bsel][`CRF_SLOT_D1][15:8] <= hwdata[7:0];
			end
		end
	end

	// ************************************************************
	// Unbanked registers.
	// ************************************************************

	// Program counter: core load wins over a bus write.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pc_reg <= `CRF_R20_RST;
		end else if (pc_load) begin
			pc_reg <= pc_value;
		end else if (wr_hit && addr_q_reg == `CRF_OFS_PC) begin
			pc_reg <= hwdata[19:0];
		end
	end

	// Vector table base.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vtb_reg <= `CRF_R20_RST;
		end else if (wr_hit && addr_q_reg == `CRF_OFS_VTB) begin
			vtb_reg <= hwdata[19:0];
		end
	end

	// Stack pointers and static base.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			usp_reg <= `CRF_R16_RST;
			tsp_reg <= `CRF_R16_RST;
			sbr_reg <= `CRF_R16_RST;
		end else if (wr_hit) begin
			if (addr_q_reg == `CRF_OFS_USP) begin
				usp_reg <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_TSP) begin
				tsp_reg <= hwdata[15:0];
			end else if (addr_q_reg == `CRF_OFS_ASP) begin
				if (flag_word[`CRF_FLG_U]) begin
					usp_reg <= hwdata[15:0];
				end else begin
					tsp_reg <= hwdata[15:0];
				end
			end else if (addr_q_reg == `CRF_OFS_SBR) begin
				sbr_reg <= hwdata[15:0];
			end
		end
	end

	// ************************************************************
	// Core-side outputs.
	// ************************************************************

	// Effective address for the requested addressing mode.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			agen_addr <= `CRF_R20_RST;
		end else begin
			case (agen_mode)
				CRF_AG_A0_IND: begin
					agen_addr <= {4'h0, bank_mem[bsel][`CRF_SLOT_A0]};
				end
				CRF_AG_A1_REL: begin
					agen_addr <= rel_addr(bank_mem[bsel][`CRF_SLOT_A1],
						agen_disp);
				end
				CRF_AG_FB_REL: begin
					agen_addr <= rel_addr(bank_mem[bsel][`CRF_SLOT_FB],
						agen_disp);
				end
				CRF_AG_SB_REL: begin
					agen_addr <= rel_addr(sbr_reg, agen_disp);
				end
				default: begin
					agen_addr <= bank_mem[bsel][`CRF_SLOT_A0][15:0] +
						{bank_mem[bsel][`CRF_SLOT_A1][3:0], 16'h0000};
				end
			endcase
		end
	end

	// Interrupt gating, single step and status views.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			step_irq <= 1'b0;
			irq_take <= 1'b0;
			pc_out <= `CRF_R20_RST;
			stack_ptr <= `CRF_R16_RST;
			bank_sel <= 1'b0;
			fetch_region <= CRF_RGN_OTHER;
		end else begin
			step_irq <= instr_done && flag_word[`CRF_FLG_D];
			irq_take <= irq_req && flag_word[`CRF_FLG_I] &&
				(irq_level >
				flag_word[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO]);
			pc_out <= pc_reg;
			stack_ptr <= pick_sp(flag_word[`CRF_FLG_U], usp_reg, tsp_reg);
			bank_sel <= bsel;
			fetch_region <= region_of(fetch_addr);
		end
	end

endmodule

//--- verif/crf_core_regs_asserts.sv
// Purpose: Concurrent checks on the ports of the core register block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of crf_core_regs.
`timescale 1ns/1ns
`include "crf_regs.svh"

module crf_core_regs_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic irq_take,
	input wire logic int_ack,
	input wire logic step_ack,
	input wire logic step_irq,
	input wire logic pc_load,
	input wire logic [19:0] pc_value,
	input wire logic [19:0] pc_out,
	input wire logic [19:0] fetch_addr,
	input wire crf_pkg::crf_region_t fetch_region,
	input wire logic bank_sel
);
	import crf_pkg::*;

	// ********************************
	// Sequences and properties.
	// ********************************

	// All checks run on the core clock and rest while reset is low.
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_taken;
		hsel && htrans[1] && hready;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_wait;
		s_taken |=> s_one_wait;
	endproperty
	property p_okay;
		hresp == 1'b0;
	endproperty
	property p_rdata;
		$changed(hrdata) |-> $rose(hreadyout);
	endproperty
	property p_bank;
		$changed(bank_sel) |-> $past(hreadyout) && !$past(hreadyout, 2);
	endproperty
	property p_irq;
		irq_take |-> $past(irq_req) && $past(irq_level) != 3'h0;
	endproperty
	property p_ack;
		int_ack |-> ##2 !irq_take;
	endproperty
	property p_step;
		step_ack |-> ##2 !step_irq;
	endproperty
	property p_pc;
		pc_load |-> ##2 pc_out == $past(pc_value, 2);
	endproperty
	property p_sfr;
		fetch_addr <= `CRF_SFR_HI |=> fetch_region == CRF_RGN_SFR;
	endproperty
	property p_spage;
		fetch_addr inside {[`CRF_SPV_LO:`CRF_SPV_HI]} |=>
			fetch_region == CRF_RGN_SPAGE;
	endproperty
	property p_fixed;
		fetch_addr >= `CRF_FIXV_LO |=> fetch_region == CRF_RGN_FIXVEC;
	endproperty

	// ********************************
	// Assertions.
	// ********************************

	a_wait: assert property (p_wait) else $error("wait state wrong");
	a_okay: assert property (p_okay) else $error("response not okay");
	a_rdata: assert property (p_rdata) else $error("read data moved");
	a_bank: assert property (p_bank) else $error("bank moved");
	a_irq: assert property (p_irq) else $error("stray take");
	a_ack: assert property (p_ack) else $error("take after ack");
	a_step: assert property (p_step) else $error("step after ack");
	a_pc: assert property (p_pc) else $error("pc load lost");
	a_sfr: assert property (p_sfr) else $error("sfr region");
	a_spage: assert property (p_spage) else $error("page region");
	a_fixed: assert property (p_fixed) else $error("fixed region");
endmodule

bind crf_core_regs crf_core_regs_chk chk_u (.core_clk, .nrst, .hsel,
	.htrans, .hready, .hreadyout, .hresp, .hrdata, .irq_req, .irq_level,
	.irq_take, .int_ack, .step_ack, .step_irq, .pc_load, .pc_value,
	.pc_out, .fetch_addr, .fetch_region, .bank_sel);

//--- verif/crf_core_regs_bench.sv
// Purpose: Self-checking bench for the core register block.
// Assumes: Each bus transfer ends when hready is seen high.
// Notes: Inputs change by non-blocking assignment after a rising edge.
`timescale 1ns/1ns
`include "crf_regs.svh"

module crf_core_regs_bench;
	import crf_pkg::*;

	// ********************************
	// Signals and tables.
	// ********************************

	logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, alu_we = 1'b0, alu_carry = 1'b0;
	logic alu_ovf = 1'b0, instr_done = 1'b0, int_ack = 1'b0;
	logic step_ack = 1'b0, trap_exec = 1'b0, irq_req = 1'b0;
	logic pc_load = 1'b0, bank_sel, step_irq, irq_take;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, irq_level = 3'h0;
	logic [5:0] trap_num = 6'h00;
	logic [15:0] alu_result = 16'h0000, agen_disp = 16'h0000, stack_ptr;
	logic [19:0] pc_value = 20'h00000, fetch_addr = 20'h00000;
	logic [19:0] agen_addr, pc_out;
	logic [19:0] ae [5];
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
	crf_agen_t agen_mode = CRF_AG_A0_IND;
	crf_region_t fetch_region;
	int n_errors = 0, samples_checked = 0;
	logic [7:0] ofs [10] = '{`CRF_OFS_D0, `CRF_OFS_D1, `CRF_OFS_D2,
		`CRF_OFS_D3, `CRF_OFS_A0, `CRF_OFS_A1, `CRF_OFS_FB,
		`CRF_OFS_USP, `CRF_OFS_TSP, `CRF_OFS_SBR};
	crf_agen_t am [5] = '{CRF_AG_A0_IND, CRF_AG_A1_REL, CRF_AG_FB_REL,
		CRF_AG_SB_REL, CRF_AG_LONG};
	logic [19:0] fa [6] = '{20'h00000, 20'h003ff, 20'h00400,
		20'hffe00, 20'hfffdb, 20'hfffdc};
	crf_region_t fr [6] = '{CRF_RGN_SFR, CRF_RGN_SFR, CRF_RGN_OTHER,
		CRF_RGN_SPAGE, CRF_RGN_SPAGE, CRF_RGN_FIXVEC};
	logic [15:0] ar [3] = '{16'h0000, 16'h8000, 16'h0001};
	logic [1:0] aco [3] = '{2'h1, 2'h2, 2'h0};
	logic [31:0] af [3] = '{32'h00000005, 32'h00000028, 32'h00000000};

	// The single slave's ready is the bus ready.
	assign hready = hreadyout;

	// Free-running core clock.
	always #5 core_clk = ~core_clk;

	crf_core_regs dut_u (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .alu_we,
		.alu_carry, .alu_result, .alu_ovf, .instr_done, .int_ack,
		.step_ack, .trap_exec, .trap_num, .irq_req, .irq_level, .pc_load,
		.pc_value, .agen_mode, .agen_disp, .fetch_addr, .agen_addr,
		.pc_out, .stack_ptr, .bank_sel, .step_irq, .irq_take,
		.fetch_region);

	// ********************************
	// Tasks.
	// ********************************

	task automatic check(input logic [31:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// One single transfer; read data is taken at the edge that ends it.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1);
		rdata = hrdata;
		check(32'(hresp), 32'h0, "resp");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string m);
		bus(1'b0, a, 32'h0);
		check(rdata, e, m);
	endtask

	function automatic logic [15:0] vv(input int i);
		return 16'((i + 1) * 16'h1001);
	endfunction

	task automatic print_verdict();
		$display("Compared %0d, mismatched %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ********************************
	// Test sequence.
	// ********************************

	// Watchdog: the run needs well under a thousand cycles.
	initial begin
		tick(5000);
		n_errors++;
		print_verdict();
	end

	// Main sequence of bus and core-side scenarios.
	initial begin
		ae = '{{4'h0, vv(4)}, {4'h0, vv(5)} + 20'h00010,
			{4'h0, vv(6)} + 20'h00010, {4'h0, vv(9)} + 20'h00010,
			{4'h0, vv(4)} + (20'(vv(5)) << 16)};
		tick(3);
		nrst <= 1'b1;
		tick(1);
		rd(`CRF_OFS_FLAG, 32'h0, "flag reset");
		for (int i = 0; i < 10; i++) begin
			wr(ofs[i], {16'hffff, vv(i)});
		end
		for (int i = 0; i < 10; i++) begin
			rd(ofs[i], {16'h0, vv(i)}, "width");
		end
		wr(`CRF_OFS_PC, 32'hffffffff);
		wr(`CRF_OFS_VTB, 32'hffffffff);
		rd(`CRF_OFS_PC, 32'h000fffff, "pc width");
		rd(`CRF_OFS_VTB, 32'h000fffff, "table width");
		rd(`CRF_OFS_LPL, {vv(2), vv(0)}, "pair low");
		rd(`CRF_OFS_LPH, {vv(3), vv(1)}, "pair high");
		rd(`CRF_OFS_LAP, {vv(5), vv(4)}, "addr pair");
		wr(`CRF_OFS_D0UB, 32'h00000077);
		rd(`CRF_OFS_D0, 32'h00007701, "upper byte");
		rd(`CRF_OFS_D0LB, 32'h00000001, "lower byte");
		for (int i = 0; i < 5; i++) begin
			agen_mode <= am[i];
			agen_disp <= 16'h0010;
			tick(2);
			check(32'(agen_addr), 32'(ae[i]), "agen");
		end
		wr(`CRF_OFS_FLAG, 32'h00000010);
		tick(2);
		check(32'(bank_sel), 32'h1, "bank select");
		wr(`CRF_OFS_D1, 32'h0000beef);
		rd(`CRF_OFS_D1, 32'h0000beef, "bank one");
		wr(`CRF_OFS_FLAG, 32'h0);
		rd(`CRF_OFS_D1, {16'h0, vv(1)}, "bank kept");
		wr(`CRF_OFS_FLAG, 32'hffffffff);
		rd(`CRF_OFS_FLAG, 32'h000070ff, "flag mask");
		check(32'(stack_ptr), {16'h0, vv(7)}, "user sp");
		rd(`CRF_OFS_ASP, {16'h0, vv(7)}, "active sp");
		int_ack <= 1'b1;
		tick(1);
		int_ack <= 1'b0;
		rd(`CRF_OFS_FLAG, 32'h0000703f, "ack");
		check(32'(stack_ptr), {16'h0, vv(8)}, "trap sp");
		for (int n = 31; n < 33; n++) begin
			wr(`CRF_OFS_FLAG, 32'h00000080);
			trap_exec <= 1'b1;
			trap_num <= 6'(n);
			tick(1);
			trap_exec <= 1'b0;
			rd(`CRF_OFS_FLAG, n > 31 ? 32'h80 : 32'h0, "trap");
		end
		wr(`CRF_OFS_FLAG, 32'h00000002);
		for (int k = 0; k < 2; k++) begin
			instr_done <= 1'b1;
			tick(1);
			instr_done <= 1'b0;
			tick(1);
			check(32'(step_irq), k == 0 ? 32'h1 : 32'h0, "step");
			tick(1);
			check(32'(step_irq), 32'h0, "step pulse");
			step_ack <= 1'b1;
			tick(1);
			step_ack <= 1'b0;
		end
		rd(`CRF_OFS_FLAG, 32'h0, "step ack");
		for (int i = 0; i < 3; i++) begin
			alu_we <= 1'b1;
			alu_result <= ar[i];
			{alu_ovf, alu_carry} <= aco[i];
			tick(1);
			alu_we <= 1'b0;
			rd(`CRF_OFS_FLAG, af[i], "alu");
		end
		wr(`CRF_OFS_FLAG, 32'h00003040);
		irq_req <= 1'b1;
		for (int l = 3; l < 5; l++) begin
			irq_level <= 3'(l);
			tick(2);
			check(32'(irq_take), l > 3 ? 32'h1 : 32'h0, "level");
		end
		wr(`CRF_OFS_FLAG, 32'h00003000);
		tick(2);
		check(32'(irq_take), 32'h0, "masked");
		irq_req <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			fetch_addr <= fa[i];
			tick(2);
			check(32'(fetch_region), 32'(fr[i]), "rgn");
		end
		pc_load <= 1'b1;
		pc_value <= 20'habcde;
		tick(1);
		pc_load <= 1'b0;
		tick(2);
		check(32'(pc_out), 32'h000abcde, "pc out");
		wr(`CRF_OFS_LPH, 32'hcafe0bad);
		rd(`CRF_OFS_D3, 32'h0000cafe, "pair write");
		wr(`CRF_OFS_D1LB, 32'h00000055);
		rd(`CRF_OFS_D1, 32'h00000b55, "byte write");
		rd(`CRF_OFS_D1UB, 32'h0000000b, "one upper");
		wr(`CRF_OFS_ASP, 32'h00001234);
		rd(`CRF_OFS_TSP, 32'h00001234, "active sp write");
		wr(8'h54, 32'hffffffff);
		rd(8'h54, 32'h0, "unmapped");
		print_verdict();
	end
endmodule
